// ### clk_susp_pkg.sv
// Constants for the clock, suspend and power-on reset controller
package clk_susp_pkg;
  localparam int CLK_PERIOD_NS = 100;
  // Register byte addresses
  localparam logic [3:0] ADDR_HW_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_DEV_MODE = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  // Field positions
  localparam int CFG_DIV_LSB = 0;
  localparam int CFG_DIV_W = 4;
  localparam int CFG_OSC_RUN = 4;
  localparam int CFG_SLOW_DIS = 5;
  localparam int MODE_SUSP_REQ = 0;
  localparam int ST_SUSPENDED = 0;
  localparam int ST_OSC_RUN = 1;
  localparam int ST_PLL_RUN = 2;
  localparam int ST_SLOW_ACT = 3;
  // Reset values
  localparam logic [3:0] DIV_RESET = 4'h0;
  localparam logic OSC_RUN_RESET = 1'b1;
  localparam logic SLOW_DIS_RESET = 1'b0;
  // Times in their own units
  localparam int SUSPEND_DELAY_US = 2000;
  localparam int WAKE_DELAY_US = 500;
  localparam int SLOW_HALF_NS = 5000;
  localparam int POR_HOLD_MIN_NS = 600;
  localparam int DIP_FILTER_US = 11;
  // Derived cycle counts
  localparam int SUSPEND_CYCLES = SUSPEND_DELAY_US * 1000 / CLK_PERIOD_NS;
  localparam int WAKE_CYCLES = WAKE_DELAY_US * 1000 / CLK_PERIOD_NS;
  localparam logic [15:0] SLOW_HALF_CYCLES =
    16'(SLOW_HALF_NS / CLK_PERIOD_NS);
  localparam logic [15:0] POR_HOLD_CYCLES =
    16'((POR_HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] DIP_CYCLES =
    16'((DIP_FILTER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  typedef enum logic [2:0] {
    AWAKE, REQ_SET, ENTER_WAIT, SUSPENDED, WAKE_WAIT
  } susp_state_t;
endpackage

// ### clock_suspend_ctrl.sv
// Clock output, suspend sequencing and power-on reset filter
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module clock_suspend_ctrl
  import clk_susp_pkg::*;
#(
  parameter int SUSPEND_DELAY = SUSPEND_CYCLES,
  parameter int WAKE_DELAY = WAKE_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic wake_input,
  input wire logic supplyAboveTrip,
  input wire logic crystal_input,
  output logic crystal_output,
  output logic clock_output_pin,
  output logic suspendIndicator,
  output logic pllRunning,
  output logic internalReset
);
  import clk_susp_pkg::*;

  localparam logic [15:0] SUSP_CNT = 16'(SUSPEND_DELAY - 1);
  localparam logic [15:0] WAKE_CNT = 16'(WAKE_DELAY - 1);

  logic [3:0] clock_output_pin_divider;
  logic osc_run_ctl;
  logic slow_clock_disable;
  logic suspend_request;
  susp_state_t state;
  logic [15:0] delayCnt;
  logic wakeLast;
  logic oscRunning;
  logic useSlow;
  logic outStopped;
  logic [15:0] halfCnt;
  logic [15:0] next_halfLimit;
  logic [15:0] dipCnt;
  logic [15:0] holdCnt;
  logic wbAccess;
  logic wbWrite;
  logic wantSlow;
  logic wantStop;
  logic dipLong;
  logic holdDone;
  logic cfgWrite;
  logic modeWrite;
  logic readReq;
  logic wakeEdge;
  logic [31:0] next_rdData;
  logic [15:0] delayLimit;
  logic delayDone;
  logic delayRun;
  logic switchNow;
  logic halfDone;

  assign wbAccess = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wbWrite = wbAccess && wb_we_i && wb_sel_i[0];
  assign cfgWrite = wbWrite && wb_adr_i == ADDR_HW_CONFIG;
  assign modeWrite = wbWrite && wb_adr_i == ADDR_DEV_MODE;
  assign readReq = wbAccess && !wb_we_i;

  // Power-on reset: dips shorter than the filter are ignored
  assign dipLong = dipCnt >= DIP_CYCLES;
  assign holdDone = holdCnt >= POR_HOLD_CYCLES - CNT_ONE;

  // Saturates so a long dip cannot wrap and clear itself
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      dipCnt <= CNT_ZERO;
    else if (supplyAboveTrip)
      dipCnt <= CNT_ZERO;
    else if (!dipLong)
      dipCnt <= dipCnt + CNT_ONE;
  end

  // Hold time counts only once the supply is back above trip
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      holdCnt <= CNT_ZERO;
    else if (!supplyAboveTrip)
      holdCnt <= CNT_ZERO;
    else if (internalReset && !holdDone)
      holdCnt <= holdCnt + CNT_ONE;
  end

  // Release waits for the full hold; a dip restarts it
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      internalReset <= 1'b1;
    else if (!supplyAboveTrip && dipLong)
      internalReset <= 1'b1;
    else if (supplyAboveTrip && holdDone)
      internalReset <= 1'b0;
  end

  // Fields fall back to reset values while the POR pulse is high
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      clock_output_pin_divider <= DIV_RESET;
    else if (internalReset)
      clock_output_pin_divider <= DIV_RESET;
    else if (cfgWrite)
      clock_output_pin_divider <= wb_dat_i[CFG_DIV_LSB +: CFG_DIV_W];
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      osc_run_ctl <= OSC_RUN_RESET;
    else if (internalReset)
      osc_run_ctl <= OSC_RUN_RESET;
    else if (cfgWrite)
      osc_run_ctl <= wb_dat_i[CFG_OSC_RUN];
  end

  // Only read in suspend; awake the bit has no effect
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      slow_clock_disable <= SLOW_DIS_RESET;
    else if (internalReset)
      slow_clock_disable <= SLOW_DIS_RESET;
    else if (cfgWrite)
      slow_clock_disable <= wb_dat_i[CFG_SLOW_DIS];
  end

  // Firmware writes it back to zero to start the entry delay
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      suspend_request <= 1'b0;
    else if (internalReset)
      suspend_request <= 1'b0;
    else if (modeWrite)
      suspend_request <= wb_dat_i[MODE_SUSP_REQ];
  end

  // Read data is zero outside an answer so a stale word never lingers
  always_comb
  begin
    next_rdData = 32'h0;
    if (readReq)
    begin
      unique case (wb_adr_i)
        ADDR_HW_CONFIG:
        begin
          next_rdData[CFG_DIV_LSB +: CFG_DIV_W] = clock_output_pin_divider;
          next_rdData[CFG_OSC_RUN] = osc_run_ctl;
          next_rdData[CFG_SLOW_DIS] = slow_clock_disable;
        end
        ADDR_DEV_MODE:
          next_rdData[MODE_SUSP_REQ] = suspend_request;
        ADDR_STATUS:
        begin
          next_rdData[ST_SUSPENDED] = suspendIndicator;
          next_rdData[ST_OSC_RUN] = oscRunning;
          next_rdData[ST_PLL_RUN] = pllRunning;
          next_rdData[ST_SLOW_ACT] = useSlow && !outStopped;
        end
        default:
          next_rdData = 32'h0;
      endcase
    end
  end

  // Bus answer one cycle after the request is seen
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wbAccess;
  end

  // Registered so read data never follows the address directly
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      wb_dat_o <= 32'h0;
    else
      wb_dat_o <= next_rdData;
  end

  // Edge detect idles low like the pin, so reset gives no false wake
  assign wakeEdge = wake_input && !wakeLast;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      wakeLast <= 1'b0;
    else if (internalReset)
      wakeLast <= 1'b0;
    else
      wakeLast <= wake_input;
  end

  // One counter serves both delays; cleared in the states before them
  assign delayLimit = (state == WAKE_WAIT) ? WAKE_CNT : SUSP_CNT;
  assign delayDone = delayCnt >= delayLimit;
  assign delayRun = (state == ENTER_WAIT || state == WAKE_WAIT) && !delayDone;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      delayCnt <= CNT_ZERO;
    else if (internalReset)
      delayCnt <= CNT_ZERO;
    else if (delayRun)
      delayCnt <= delayCnt + CNT_ONE;
    else if (state == REQ_SET || state == SUSPENDED)
      delayCnt <= CNT_ZERO;
  end

  // Suspend sequencing
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= AWAKE;
      suspendIndicator <= 1'b0;
    end
    else if (internalReset)
    begin
      state <= AWAKE;
      suspendIndicator <= 1'b0;
    end
    else
    begin
      unique case (state)
        AWAKE:
          if (suspend_request)
            state <= REQ_SET;
        REQ_SET:
          // Entry delay starts when firmware clears the request
          if (!suspend_request)
            state <= ENTER_WAIT;
        ENTER_WAIT:
          if (delayDone)
          begin
            state <= SUSPENDED;
            suspendIndicator <= 1'b1;
          end
        SUSPENDED:
          if (wakeEdge)
            state <= WAKE_WAIT;
        WAKE_WAIT:
          if (delayDone)
          begin
            state <= AWAKE;
            suspendIndicator <= 1'b0;
          end
      endcase
    end
  end

  // Oscillator amplifier; an external clock simply overdrives the input
  assign oscRunning = osc_run_ctl && !suspendIndicator;
  assign crystal_output = oscRunning ? !crystal_input : 1'b0;
  // PLL runs only with its reference present
  assign pllRunning = oscRunning;

  // Awake with the oscillator off leaves no source to divide
  always_comb
  begin
    wantSlow = suspendIndicator;
    if (suspendIndicator)
      wantStop = slow_clock_disable;
    else
      wantStop = !pllRunning;
  end

  // Half period: divider+1 for the normal clock, scaled to ref_clk
  always_comb
  begin
    if (useSlow)
      next_halfLimit = SLOW_HALF_CYCLES - CNT_ONE;
    else
      next_halfLimit = {12'h0, clock_output_pin_divider};
  end

  // Source changes only while the output is low, so no runt pulse
  assign switchNow = !clock_output_pin &&
    (useSlow != wantSlow || outStopped != wantStop);
  assign halfDone = halfCnt >= next_halfLimit;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      useSlow <= 1'b0;
      outStopped <= 1'b0;
    end
    else if (switchNow)
    begin
      useSlow <= wantSlow;
      outStopped <= wantStop;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      halfCnt <= CNT_ZERO;
    else if (switchNow || outStopped || halfDone)
      halfCnt <= CNT_ZERO;
    else
      halfCnt <= halfCnt + CNT_ONE;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      clock_output_pin <= 1'b0;
    else if (!switchNow && outStopped)
      clock_output_pin <= 1'b0;
    else if (!switchNow && halfDone)
      clock_output_pin <= !clock_output_pin;
  end
endmodule

// ### clock_suspend_ctrl_properties.sv
// Concurrent checks on the clock and suspend controller ports
`timescale 1ns/1ps
module clock_suspend_ctrl_properties
#(
  parameter int SUSPEND_DELAY = 20000,
  parameter int WAKE_DELAY = 5000
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wake_input,
  input wire logic supplyAboveTrip,
  input wire logic crystal_input,
  input wire logic crystal_output,
  input wire logic suspendIndicator,
  input wire logic pllRunning,
  input wire logic internalReset
);
  // Slack for the wake sequencer's own edge detect
  localparam int WLO = WAKE_DELAY - 2;
  localparam int WHI = WAKE_DELAY + 4;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  ack_next_cycle_a: assert property
    (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  idle_data_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data outside ack");
  osc_output_a: assert property
    (crystal_output == (pllRunning & ~crystal_input))
    else $error("oscillator output wrong");
  suspend_stops_pll_a: assert property
    ($rose(suspendIndicator) |-> !pllRunning)
    else $error("pll runs in suspend");
  por_hold_a: assert property
    ($fell(internalReset) |-> $past(supplyAboveTrip, 5))
    else $error("reset released early");
  short_dip_a: assert property
    ($fell(supplyAboveTrip) && !internalReset |=> !internalReset[*8])
    else $error("reset on short dip");
  wake_delay_a: assert property
    ($rose(wake_input) && suspendIndicator
      |-> ##[WLO:WHI] !suspendIndicator)
    else $error("wake delay wrong");
  cover property ($rose(suspendIndicator));
  cover property ($fell(suspendIndicator));
  cover property ($rose(internalReset));
endmodule

// ### clock_suspend_ctrl_tb.sv
// Directed bench for the clock and suspend controller
`timescale 1ns/1ps
module clock_suspend_ctrl_tb;
  import clk_susp_pkg::*;
  // Short delays keep the run brief
  localparam int SD = 40;
  localparam int WD = 20;
  logic ref_clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r;
  logic wb_ack_o, wake_input = 0, supplyAboveTrip = 1, crystal_input = 0;
  logic crystal_output, clock_output_pin, suspendIndicator, pllRunning;
  logic internalReset;
  int failures = 0, n_compared = 0, p;
  time t0;
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) crystal_input <= ~crystal_input;
  clock_suspend_ctrl #(.SUSPEND_DELAY(SD), .WAKE_DELAY(WD))
    u_clock_suspend_ctrl (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .wake_input, .supplyAboveTrip, .crystal_input, .crystal_output,
    .clock_output_pin, .suspendIndicator, .pllRunning, .internalReset);
  task automatic chk(input logic [31:0] g, e, input string m);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1) @(posedge ref_clk);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic per();
    @(posedge clock_output_pin);
    t0 = $time;
    @(posedge clock_output_pin);
    p = int'(($time - t0) / 100);
  endtask
  task automatic suspend(input logic [31:0] cfg);
    bus(1, ADDR_HW_CONFIG, cfg);
    bus(1, ADDR_DEV_MODE, 32'h1);
    bus(1, ADDR_DEV_MODE, 32'h0);
    t0 = $time;
    @(posedge suspendIndicator);
    p = int'(($time - t0) / 100);
    #1;
    chk(p >= SD - 2 && p <= SD + 3, 1, "suspend delay");
    chk(pllRunning, 0, "pll in suspend");
  endtask
  task automatic wake();
    @(posedge ref_clk);
    wake_input <= 1'b1;
    t0 = $time;
    @(posedge ref_clk);
    wake_input <= 1'b0;
    @(negedge suspendIndicator);
    p = int'(($time - t0) / 100);
    #1;
    chk(p >= WD - 2 && p <= WD + 4, 1, "wake delay");
    chk(pllRunning, 1, "pll after wake");
  endtask
  task automatic conclude();
    $display("failures=%0d compared=%0d", failures, n_compared);
    if (failures == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    while (internalReset !== 1'b0) @(posedge ref_clk);
    @(posedge ref_clk);
    bus(0, ADDR_HW_CONFIG, 0);
    chk(r, 32'h10, "config reset");
    bus(0, ADDR_STATUS, 0);
    chk(r, 32'h6, "status awake");
    bus(0, 4'hc, 0);
    chk(r, 32'h0, "unmapped read");
    for (int d = 0; d < 16; d += 5)
    begin
      bus(1, ADDR_HW_CONFIG, 32'h10 | d);
      per();
      per();
      chk(p, 2 * (d + 1), "divided period");
    end
    bus(1, ADDR_HW_CONFIG, 32'h0);
    chk(pllRunning, 0, "oscillator off");
    suspend(32'h11);
    per();
    per();
    chk(p, 100, "slow clock period");
    bus(0, ADDR_STATUS, 0);
    chk(r, 32'h9, "status slow");
    wake();
    per();
    per();
    chk(p, 4, "normal clock back");
    suspend(32'h31);
    // A high phase already under way may finish before the stop
    repeat (4) @(posedge ref_clk);
    repeat (120) @(posedge ref_clk) chk(clock_output_pin, 0, "held");
    bus(0, ADDR_STATUS, 0);
    chk(r, 32'h1, "status stopped");
    wake();
    @(posedge ref_clk);
    supplyAboveTrip <= 1'b0;
    repeat (100) @(posedge ref_clk);
    supplyAboveTrip <= 1'b1;
    chk(internalReset, 0, "short dip");
    repeat (4) @(posedge ref_clk);
    supplyAboveTrip <= 1'b0;
    repeat (120) @(posedge ref_clk);
    chk(internalReset, 1, "long dip");
    supplyAboveTrip <= 1'b1;
    t0 = $time;
    @(negedge internalReset);
    p = int'(($time - t0) / 100);
    chk(p >= 5 && p <= 7, 1, "reset hold");
    @(posedge ref_clk);
    bus(0, ADDR_HW_CONFIG, 0);
    chk(r, 32'h10, "config after dip");
    conclude();
  end
  initial
  begin
    #2000000;
    failures++;
    conclude();
  end
endmodule
bind clock_suspend_ctrl clock_suspend_ctrl_properties
  #(.SUSPEND_DELAY(SUSPEND_DELAY), .WAKE_DELAY(WAKE_DELAY))
  u_props (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
  .wake_input, .supplyAboveTrip, .crystal_input, .crystal_output,
  .suspendIndicator, .pllRunning, .internalReset);
